/* File: inc/erd_consts.svh */
// Constants for the egress reclassification and drop-eligible marker.
// Assumes a single 40 MHz clock and a 32-bit AXI4-Lite register port.
//
// Notes on behaviour
// - Egress overrides use IP header matches only
// - Quintuple beats precedence/DSCP when several match
// - Unset quintuple parameters keep precedence/DSCP value
// - DSCP entry replaces a matching precedence entry
// - Unoverridden parameters keep the ingress result
// - Overrides disabled: silently ignored, no error
// - Tag priority: three bits, separate DE
// - DE zero: committed traffic, not discard eligible
// - DE one: excess traffic, dropped first
// - DE unused: send zero, ignore on receive
// - Service tag DE bit follows same meaning
// - Backbone tag DE wins over service tag
// - Backbone encapsulation marks both DE bits
// - Access ingress may take profile from DE
// - Metering exceed also turns packets out-of-profile
// - Backbone egress copies DE into tunnel fields
// - Backbone ingress maps DE to internal profile
// - Egress priority marked from profile and class
// - Ingress classifies on priority with DE
// - Egress marking uses overridden class and profile
// - Ingress remark decision ignores egress overrides
`ifndef ERD_CONSTS_SVH
`define ERD_CONSTS_SVH

// ----------------------------------------
// Register byte offsets and table bases (address bits [7:5])
// ----------------------------------------
`define ERD_CTRL_OFS 8'h00
`define ERD_STAT_OFS 8'h04
`define ERD_PCP_IN_OFS 8'h08
`define ERD_PCP_OUT_OFS 8'h0c
`define ERD_EXP_IN_OFS 8'h10
`define ERD_EXP_OUT_OFS 8'h14
`define ERD_CLS_OFS 8'h18
`define ERD_PREC_BASE 3'h1
`define ERD_DSCP_BASE 3'h2

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ERD_CTRL_OVR 0
`define ERD_CTRL_DE_TX 1
`define ERD_CTRL_DE_RX 2
`define ERD_ENT_EN 8
`define ERD_ENT_FC_LO 9
`define ERD_ENT_FC_SET 12
`define ERD_ENT_PR_SET 13
`define ERD_ENT_PR 14
`define ERD_TAG_DE 12
`define ERD_CTRL_RST 32'h0000_0007
`define ERD_MAP_RST 32'h00fa_c688
`define ERD_RESP_OKAY 2'h0
`define ERD_RESP_SLVERR 2'h2

`endif

/* File: inc/erd_pkg.sv */
// Types for the egress reclassification and drop-eligible marker.
// Assumes erd_consts.svh carries all numeric constants.
package erd_pkg;
   typedef enum logic [1:0] {
      ERD_ACC_IN = 2'b00,
      ERD_BB_IN = 2'b01,
      ERD_ACC_OUT = 2'b10,
      ERD_BB_OUT = 2'b11
   } erd_dir_t;
endpackage

/* File: hw/erd_marker.sv */
// Per-packet class/profile resolution and tag DE/priority marking.
// Assumes upstream supplies parsed tag, ToS byte and quintuple match result.
`include "erd_consts.svh"

module erd_marker import erd_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic in_valid,
   output logic in_ready,
   input wire erd_dir_t in_dir,
   input wire logic [2:0] in_fc,
   input wire logic in_prof,
   input wire logic in_remark,
   input wire logic in_is_ip,
   input wire logic [7:0] in_tos,
   input wire logic in_q5_hit,
   input wire logic in_q5_fc_set,
   input wire logic [2:0] in_q5_fc,
   input wire logic in_q5_prof_set,
   input wire logic in_q5_prof,
   input wire logic [15:0] in_tci,
   input wire logic in_has_bvid,
   input wire logic in_has_itag,
   input wire logic in_idei,
   input wire logic in_exceed,
   output logic out_valid,
   input wire logic out_ready,
   output erd_dir_t out_dir,
   output logic [2:0] out_fc,
   output logic out_prof,
   output logic [15:0] out_tci,
   output logic out_idei,
   output logic [2:0] out_exp
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [2:0] erd_lookup(input logic [31:0] map, input logic [2:0] idx);
      erd_lookup = map[idx*3 +: 3];
   endfunction

   function automatic logic [31:0] erd_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      erd_merge = res;
   endfunction

   default clocking erd_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [31:0] ctrl_ff, pcp_in_ff, pcp_out_ff, exp_in_ff, exp_out_ff, cls_ff, cnt_ff;
   logic [14:0] prec_ff [8];
   logic [14:0] dscp_ff [8];
   logic bvalid_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic wr_go, rd_go, wr_map;
   logic [31:0] nxt_rdata;
   logic nxt_rmap;

   // Both halves of a write are taken together so address and data never split
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
   assign rd_go = s_axi_arvalid && !rvalid_ff;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   always_comb begin
      wr_map = 1'b1;
      case (s_axi_awaddr)
         `ERD_CTRL_OFS, `ERD_PCP_IN_OFS, `ERD_PCP_OUT_OFS, `ERD_EXP_IN_OFS,
         `ERD_EXP_OUT_OFS, `ERD_CLS_OFS: wr_map = 1'b1;
         default: wr_map = (s_axi_awaddr[7:5] == `ERD_PREC_BASE) || (s_axi_awaddr[7:5] == `ERD_DSCP_BASE);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= `ERD_CTRL_RST;
         pcp_in_ff <= `ERD_MAP_RST;
         pcp_out_ff <= `ERD_MAP_RST;
         exp_in_ff <= `ERD_MAP_RST;
         exp_out_ff <= `ERD_MAP_RST;
         cls_ff <= `ERD_MAP_RST;
      end else if (wr_go) begin
         case (s_axi_awaddr)
            `ERD_CTRL_OFS: ctrl_ff <= erd_merge(ctrl_ff, s_axi_wdata, s_axi_wstrb) & 32'h0000_0007;
            `ERD_PCP_IN_OFS: pcp_in_ff <= erd_merge(pcp_in_ff, s_axi_wdata, s_axi_wstrb) & 32'h00ff_ffff;
            `ERD_PCP_OUT_OFS: pcp_out_ff <= erd_merge(pcp_out_ff, s_axi_wdata, s_axi_wstrb) & 32'h00ff_ffff;
            `ERD_EXP_IN_OFS: exp_in_ff <= erd_merge(exp_in_ff, s_axi_wdata, s_axi_wstrb) & 32'h00ff_ffff;
            `ERD_EXP_OUT_OFS: exp_out_ff <= erd_merge(exp_out_ff, s_axi_wdata, s_axi_wstrb) & 32'h00ff_ffff;
            `ERD_CLS_OFS: cls_ff <= erd_merge(cls_ff, s_axi_wdata, s_axi_wstrb) & 32'h00ff_ffff;
            default: ;
         endcase
      end
   end

   // Match tables: precedence entry i matches precedence value i
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 8; i++) begin
            prec_ff[i] <= 15'h0000;
            dscp_ff[i] <= 15'h0000;
         end
      end else if (wr_go) begin
         if (s_axi_awaddr[7:5] == `ERD_PREC_BASE) begin
            prec_ff[s_axi_awaddr[4:2]] <= 15'(erd_merge({17'h00000, prec_ff[s_axi_awaddr[4:2]]},
                                                        s_axi_wdata, s_axi_wstrb) & 32'h0000_7f00);
         end
         if (s_axi_awaddr[7:5] == `ERD_DSCP_BASE) begin
            dscp_ff[s_axi_awaddr[4:2]] <= 15'(erd_merge({17'h00000, dscp_ff[s_axi_awaddr[4:2]]},
                                                        s_axi_wdata, s_axi_wstrb) & 32'h0000_7f3f);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= `ERD_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_map ? `ERD_RESP_OKAY : `ERD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_rmap = 1'b1;
      case (s_axi_araddr)
         `ERD_CTRL_OFS: nxt_rdata = ctrl_ff;
         `ERD_STAT_OFS: nxt_rdata = cnt_ff;
         `ERD_PCP_IN_OFS: nxt_rdata = pcp_in_ff;
         `ERD_PCP_OUT_OFS: nxt_rdata = pcp_out_ff;
         `ERD_EXP_IN_OFS: nxt_rdata = exp_in_ff;
         `ERD_EXP_OUT_OFS: nxt_rdata = exp_out_ff;
         `ERD_CLS_OFS: nxt_rdata = cls_ff;
         default: begin
            if (s_axi_araddr[7:5] == `ERD_PREC_BASE) begin
               nxt_rdata = {17'h00000, prec_ff[s_axi_araddr[4:2]]};
            end else if (s_axi_araddr[7:5] == `ERD_DSCP_BASE) begin
               nxt_rdata = {17'h00000, dscp_ff[s_axi_araddr[4:2]]};
            end else begin
               nxt_rmap = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= `ERD_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rmap ? `ERD_RESP_OKAY : `ERD_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   wr_resp_a: assert property (wr_go |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response missing after accepted write");

   rd_resp_a: assert property (rd_go |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response missing after accepted read");

   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");

   // ----------------------------------------
   // Class and profile resolution
   // ----------------------------------------
   logic in_fire, ovr, ingress, d_hit, e_hit, rx_de, mark_prof, tx_de;
   logic [2:0] d_idx, fc, mark_fc;
   logic prof;
   logic [14:0] ent;

   assign in_ready = out_ready || !out_valid;
   assign in_fire = in_valid && in_ready;
   assign ingress = (in_dir == ERD_ACC_IN) || (in_dir == ERD_BB_IN);
   // Only egress toward the access side with IP headers may be overridden; else silently untouched
   assign ovr = ctrl_ff[`ERD_CTRL_OVR] && (in_dir == ERD_ACC_OUT) && in_is_ip;

   always_comb begin
      d_hit = 1'b0;
      d_idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (dscp_ff[i][`ERD_ENT_EN] && (dscp_ff[i][5:0] == in_tos[7:2])) begin
            d_hit = 1'b1;
            d_idx = 3'(i);
         end
      end
   end

   // A DSCP hit replaces the precedence entry wholesale
   assign ent = d_hit ? dscp_ff[d_idx] : prec_ff[in_tos[7:5]];
   assign e_hit = d_hit || prec_ff[in_tos[7:5]][`ERD_ENT_EN];
   // Backbone tag first, service tag only when no backbone tag is present
   assign rx_de = (in_has_itag && !in_has_bvid) ? in_idei : in_tci[`ERD_TAG_DE];

   always_comb begin
      fc = in_fc;
      prof = in_prof;
      if (ingress) begin
         fc = erd_lookup(cls_ff, in_tci[15:13]);
         prof = !(ctrl_ff[`ERD_CTRL_DE_RX] && rx_de) && !in_exceed;
      end else begin
         if (ovr && e_hit) begin
            if (ent[`ERD_ENT_FC_SET]) begin
               fc = ent[`ERD_ENT_FC_LO +: 3];
            end
            if (ent[`ERD_ENT_PR_SET]) begin
               prof = ent[`ERD_ENT_PR];
            end
         end
         // Quintuple applied last so it has the final word; unset fields pass through
         if (ovr && in_q5_hit) begin
            if (in_q5_fc_set) begin
               fc = in_q5_fc;
            end
            if (in_q5_prof_set) begin
               prof = in_q5_prof;
            end
         end
      end
   end

   // Ingress remark fixes marking to the ingress result
   assign mark_fc = in_remark ? in_fc : fc;
   assign mark_prof = in_remark ? in_prof : prof;
   assign tx_de = ctrl_ff[`ERD_CTRL_DE_TX] && !mark_prof;

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_valid <= 1'b0;
      end else if (in_ready) begin
         out_valid <= in_valid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_dir <= ERD_ACC_IN;
         out_fc <= 3'h0;
         out_prof <= 1'b0;
         out_tci <= 16'h0000;
         out_idei <= 1'b0;
         out_exp <= 3'h0;
      end else if (in_fire) begin
         out_dir <= in_dir;
         out_fc <= fc;
         out_prof <= prof;
         out_exp <= mark_prof ? erd_lookup(exp_in_ff, mark_fc) : erd_lookup(exp_out_ff, mark_fc);
         if (ingress) begin
            out_tci <= in_tci;
            out_idei <= in_idei;
         end else begin
            out_tci <= {mark_prof ? erd_lookup(pcp_in_ff, mark_fc) : erd_lookup(pcp_out_ff, mark_fc),
                        tx_de, in_tci[11:0]};
            out_idei <= in_has_itag ? tx_de : in_idei;
         end
      end
   end

   // Packets seen, wraps; visible in the status register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 32'h0000_0000;
      end else if (in_fire) begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_tci) && $stable(out_fc))
      else $error("output changed while stalled");

   non_ip_a: assert property (in_fire && !in_is_ip && (in_dir == ERD_ACC_OUT) |=>
      out_fc == $past(in_fc) && out_prof == $past(in_prof))
      else $error("non-IP packet was reclassified");

   ovr_off_a: assert property (in_fire && !ctrl_ff[`ERD_CTRL_OVR] && !ingress |=>
      out_fc == $past(in_fc) && out_prof == $past(in_prof))
      else $error("override applied while disabled");

   q5_wins_a: assert property (in_fire && ovr && in_q5_hit && in_q5_fc_set |=> out_fc == $past(in_q5_fc))
      else $error("quintuple class did not win");

   de_zero_a: assert property (in_fire && !ingress && !ctrl_ff[`ERD_CTRL_DE_TX] |=>
      !out_tci[`ERD_TAG_DE])
      else $error("DE sent while marking disabled");

   de_mark_a: assert property (in_fire && !ingress && !in_remark && ctrl_ff[`ERD_CTRL_DE_TX] |=>
      out_tci[`ERD_TAG_DE] == !out_prof)
      else $error("DE does not follow profile");

   exceed_a: assert property (in_fire && ingress && in_exceed |=> !out_prof)
      else $error("exceeding packet left in profile");

   bvid_pref_a: assert property (in_fire && ingress && in_has_bvid && ctrl_ff[`ERD_CTRL_DE_RX] &&
      !in_tci[`ERD_TAG_DE] && !in_exceed |=> out_prof)
      else $error("service tag DE used over backbone tag");

   idei_a: assert property (in_fire && !ingress && in_has_itag |=> out_idei == out_tci[`ERD_TAG_DE])
      else $error("service tag DE differs from backbone DE");

   ingress_pass_a: assert property (in_fire && ingress |=>
      out_tci == $past(in_tci) && out_idei == $past(in_idei))
      else $error("ingress tag was altered");

   vid_keep_a: assert property (in_fire && !ingress |=> out_tci[11:0] == $past(in_tci[11:0]))
      else $error("egress marking altered the VLAN identifier");

   cnt_step_a: assert property (in_fire |=> cnt_ff == $past(cnt_ff) + 32'h0000_0001)
      else $error("packet count did not advance");

endmodule

/* File: tb/erd_sink.sv */
// Far-side model: downstream peer that accepts marked descriptors.
// Assumes it shares aclk and aresetn with the marker.
module erd_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic out_valid,
   input wire logic [15:0] out_tci,
   input wire logic slow,
   output logic out_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Stall pattern
   // ----------------------------------------
   logic [1:0] cnt_ff;
   logic de_seen_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 2'h0;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
      end
   end
   // A slow peer accepts one cycle in four, so held outputs get exercised
   assign out_ready = !slow || (cnt_ff == 2'h3);
   // Priority in [15:13], drop flag alone in [12]
   // Drop flag 1 marks excess traffic, 0 committed traffic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         de_seen_ff <= 1'b0;
      end else if (out_valid && out_ready) begin
         de_seen_ff <= out_tci[12];
      end
   end
   // Nothing else acts on the drop flag, as a peer that ignores it would
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the egress reclassification and drop-eligible marker.
// Assumes erd_pkg, erd_consts.svh and the sink model are compiled first.
`include "erd_consts.svh"
module testbench import erd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, in_tos;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic in_valid, in_ready, in_prof, in_remark, in_is_ip, q5_hit, q5_fs, q5_ps, q5_p;
   logic has_bvid, has_itag, in_idei, in_exceed, out_valid, out_ready, out_prof, out_idei, slow;
   logic [2:0] in_fc, q5_f, out_fc, out_exp, c_fc, c_exp;
   logic [15:0] in_tci, out_tci, c_tci;
   logic c_prof, c_idei;
   erd_dir_t in_dir, out_dir;
   int n_errors, cmp_count;
   logic [31:0] d;
   logic [1:0] r;

   erd_marker DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_valid(in_valid),
      .in_ready(in_ready), .in_dir(in_dir), .in_fc(in_fc), .in_prof(in_prof), .in_remark(in_remark),
      .in_is_ip(in_is_ip), .in_tos(in_tos), .in_q5_hit(q5_hit), .in_q5_fc_set(q5_fs), .in_q5_fc(q5_f),
      .in_q5_prof_set(q5_ps), .in_q5_prof(q5_p), .in_tci(in_tci), .in_has_bvid(has_bvid),
      .in_has_itag(has_itag), .in_idei(in_idei), .in_exceed(in_exceed), .out_valid(out_valid),
      .out_ready(out_ready), .out_dir(out_dir), .out_fc(out_fc), .out_prof(out_prof),
      .out_tci(out_tci), .out_idei(out_idei), .out_exp(out_exp));
   erd_sink peer (.aclk(aclk), .aresetn(aresetn), .out_valid(out_valid), .out_tci(out_tci),
      .slow(slow), .out_ready(out_ready));

   always #12.5 aclk = !aclk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up();
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hang(input int n);
      if (n >= 200) begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a; wdata <= v; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!(awready && wready) && n < 200);
      hang(n);
      awvalid <= 1'b0; wvalid <= 1'b0; n = 0;
      do begin @(posedge aclk); n++; end while (!bvalid && n < 200);
      hang(n);
      r = bresp; bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (!arready && n < 200);
      hang(n);
      arvalid <= 1'b0; n = 0;
      do begin @(posedge aclk); n++; end while (!rvalid && n < 200);
      hang(n);
      d = rdata; r = rresp; rready <= 1'b0;
   endtask
   // Other descriptor fields are set by the caller beforehand
   task automatic send(input logic [1:0] dr, input logic [2:0] f, input logic p, input logic [15:0] t);
      int n;
      n = 0;
      @(posedge aclk);
      in_valid <= 1'b1; in_dir <= erd_dir_t'(dr); in_fc <= f; in_prof <= p; in_tci <= t;
      do begin @(posedge aclk); n++; end while (!in_ready && n < 200);
      hang(n);
      in_valid <= 1'b0; n = 0;
      do begin @(posedge aclk); n++; end while (!(out_valid && out_ready) && n < 200);
      hang(n);
      c_fc = out_fc; c_prof = out_prof; c_tci = out_tci; c_idei = out_idei; c_exp = out_exp;
      check("dir", {30'h0, out_dir}, {30'h0, dr});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(`ERD_CTRL_OFS); check("ctrl", d, `ERD_CTRL_RST);
      rd(`ERD_CLS_OFS); check("cls", d, `ERD_MAP_RST);
      rd(8'hfc); check("rresp", {30'h0, r}, {30'h0, `ERD_RESP_SLVERR}); check("rdata", d, 32'h0);
      wr(`ERD_STAT_OFS, 32'h1); check("stat wr", {30'h0, r}, {30'h0, `ERD_RESP_SLVERR});
   endtask
   task automatic t_ingress();
      for (int dr = 0; dr < 2; dr++) begin
         for (int i = 0; i < 16; i++) begin
            send(dr[1:0], 3'h0, 1'b0, {i[3:0], 12'h123});
            check("in fc", {29'h0, c_fc}, {29'h0, i[3:1]});
            check("in prof", {31'h0, c_prof}, {31'h0, !i[0]});
            check("in tci", {16'h0, c_tci}, {16'h0, i[3:0], 12'h123});
         end
      end
      in_exceed <= 1'b1;
      send(2'h0, 3'h0, 1'b0, 16'h4000);
      check("exceed", {31'h0, c_prof}, 32'h0);
      in_exceed <= 1'b0;
      wr(`ERD_CTRL_OFS, 32'h3);
      send(2'h0, 3'h0, 1'b0, 16'h5000);
      check("de off", {31'h0, c_prof}, 32'h1);
      wr(`ERD_CTRL_OFS, 32'h7);
   endtask
   task automatic t_pbb();
      has_itag <= 1'b1; in_idei <= 1'b1;
      send(2'h0, 3'h0, 1'b0, 16'h2000);
      check("idei", {31'h0, c_prof}, 32'h0);
      has_bvid <= 1'b1;
      send(2'h0, 3'h0, 1'b0, 16'h2000);
      check("bvid", {31'h0, c_prof}, 32'h1);
      for (int p = 0; p < 2; p++) begin
         send(2'h3, 3'h5, p[0], 16'h0777);
         check("bb tci", {16'h0, c_tci}, {16'h0, 3'h5, !p[0], 12'h777});
         check("bb idei", {31'h0, c_idei}, {31'h0, !p[0]});
         check("bb exp", {29'h0, c_exp}, 32'h5);
      end
      has_itag <= 1'b0; has_bvid <= 1'b0; in_idei <= 1'b0;
   endtask
   // Ingress class 1 in profile; out-of-profile priority map is zeroed
   task automatic eg(input logic [2:0] f, input logic p);
      send(2'h2, 3'h1, 1'b1, 16'h00a5);
      check("eg fc", {29'h0, c_fc}, {29'h0, f});
      check("eg prof", {31'h0, c_prof}, {31'h0, p});
      check("eg tci", {16'h0, c_tci}, {16'h0, p ? f : 3'h0, !p, 12'h0a5});
   endtask
   task automatic t_egress();
      wr(`ERD_PCP_OUT_OFS, 32'h0);
      in_is_ip <= 1'b1; in_tos <= 8'hb8; slow <= 1'b1;
      wr(8'h34, 32'h3500);
      eg(3'h2, 1'b0);
      slow <= 1'b0;
      wr(8'h40, 32'h172e);
      eg(3'h3, 1'b1);
      q5_hit <= 1'b1; q5_fs <= 1'b1; q5_f <= 3'h6; q5_ps <= 1'b1; q5_p <= 1'b0;
      eg(3'h6, 1'b0);
      in_remark <= 1'b1;
      send(2'h2, 3'h1, 1'b1, 16'h00a5);
      check("remark", {16'h0, c_tci}, 32'h20a5);
      in_remark <= 1'b0; q5_fs <= 1'b0;
      eg(3'h3, 1'b0);
      send(2'h3, 3'h1, 1'b1, 16'h00a5);
      check("bb ovr", {28'h0, c_fc, c_prof}, 32'h3);
      in_is_ip <= 1'b0;
      eg(3'h1, 1'b1);
      in_is_ip <= 1'b1;
      wr(`ERD_CTRL_OFS, 32'h6);
      check("ovr off", {30'h0, r}, {30'h0, `ERD_RESP_OKAY});
      eg(3'h1, 1'b1);
      rd(`ERD_STAT_OFS); check("count", d, 32'h0000_002e);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; in_valid = 0; in_dir = ERD_ACC_IN;
      in_fc = 0; in_prof = 0; in_remark = 0; in_is_ip = 0; in_tos = 0; q5_hit = 0; q5_fs = 0;
      q5_f = 0; q5_ps = 0; q5_p = 0; in_tci = 0; has_bvid = 0; has_itag = 0; in_idei = 0;
      in_exceed = 0; slow = 0; n_errors = 0; cmp_count = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ingress();
      t_pbb();
      t_egress();
      wrap_up();
   end
endmodule
